//--- inc/adcc_pkg.sv
package adcc_pkg;
  // register byte addresses (own choice, aligned words)
  localparam logic [7:0] ADDR_CONV_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_SRC_CFG     = 8'h04;
  localparam logic [7:0] ADDR_RES_HIGH    = 8'h08;
  localparam logic [7:0] ADDR_RES_LOW     = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLEAR   = 8'h18;
  localparam logic [7:0] ADDR_CONV_RESULT = 8'h1C;

  // conversion_control fields
  localparam int BIT_START   = 7;
  localparam int BIT_BUSY    = 6;
  localparam int BIT_POWER   = 5;
  localparam int BIT_JUSTIFY = 4;
  localparam int CHSEL_HI    = 3;
  // source_reference_clock_config fields
  localparam int SRC_HI = 7;
  localparam int SRC_LO = 5;
  localparam int REF_HI = 4;
  localparam int REF_LO = 3;
  localparam int DIV_HI = 2;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET  = 8'h00;

  // input source codes
  localparam logic [2:0] SRC_EXT      = 3'h0;
  localparam logic [2:0] SRC_BANDGAP  = 3'h1;
  localparam logic [2:0] SRC_SMOKE_A  = 3'h2;
  localparam logic [2:0] SRC_SMOKE_B  = 3'h3;
  localparam logic [2:0] SRC_HORN     = 3'h4;
  localparam logic [1:0] REF_ANALOG   = 2'h1;
  localparam logic [3:0] CHAN_LAST    = 4'h7;

  // one-hot analog mux selects
  localparam int MUX_W       = 12;
  localparam int MUX_BANDGAP = 8;
  localparam int MUX_SMOKE_A = 9;
  localparam int MUX_SMOKE_B = 10;
  localparam int MUX_HORN    = 11;

  localparam int RES_W   = 12;
  localparam int IRQ_W   = 2;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_START = 1;
  // sampling phase length in converter clocks
  localparam int CONV_CLKS = 16;

  typedef enum logic [1:0] {ADCC_IDLE, ADCC_SAMPLE, ADCC_CONVERT} adcc_state_e;
endpackage : adcc_pkg

//--- hdl/adcc_clkdiv.sv
`timescale 1ns/1ps
module adcc_clkdiv
  import adcc_pkg::*;
#(
  parameter int DIV_W = 7
) (
  input  wire logic       clk,     // system clock
  input  wire logic       rst,     // async reset, active high
  input  wire logic       run,     // divider runs while high
  input  wire logic [2:0] div_sel, // log2 of division ratio
  output logic            tick     // one pulse per converter clock
);
  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] limit;

  // ratio 2**div_sel, terminal count one below
  assign limit = DIV_W'((1 << div_sel) - 1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (!run || cnt_ff >= limit) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= run && (cnt_ff >= limit);
    end
  end
endmodule : adcc_clkdiv

//--- hdl/adcc_top.sv
`timescale 1ns/1ps
//
// Behaviour
// RULE1: source 000 feeds selected external channel
// RULE2: source codes 101-111 act like 000
// RULE3: source 001 feeds bandgap voltage
// RULE4: source 010 feeds smoke amp A
// RULE5: source 011 feeds smoke amp B
// RULE6: source 100 feeds horn line amp
// RULE7: software avoids external pin with internal source
// RULE8: reference 00 uses external reference pin
// RULE9: reference 01 uses internal analog supply
// RULE10: reference 1x uses external reference pin
// RULE11: software leaves ref pin unconfigured with 01
// RULE12: divider codes 0-3 give fsys/1,2,4,8
// RULE13: divider codes 4-7 give fsys/16..128
// RULE14: start bit low-high-low starts conversion
// RULE15: busy set on start, cleared with interrupt
// RULE16: justify selects result byte layout
// RULE17: power off stops converter, result held
// RULE18: reset clears control; busy ignores writes
// RULE19: channel codes 0-7 pick pin, else none
module adcc_top
  import adcc_pkg::*;
(
  input  wire logic                    clk,            // 20 MHz system clock
  input  wire logic                    rst,            // async reset, active high
  input  wire logic                    psel,           // apb select
  input  wire logic                    penable,        // apb access phase
  input  wire logic                    pwrite,         // apb write
  input  wire logic [7:0]              paddr,          // apb byte address
  input  wire logic [31:0]             pwdata,         // apb write data
  output logic      [31:0]             prdata,         // apb read data
  output logic                         pready,         // apb ready
  output logic                         pslverr,        // apb error, unmapped
  output logic                         irq,            // level interrupt
  input  wire logic                    conv_done,      // analog core end of conversion
  input  wire logic [adcc_pkg::RES_W-1:0] conv_data,   // analog core result
  output logic                         conv_clk_tick,  // converter clock pulse
  output logic                         conv_start,     // one-cycle start to analog core
  output logic                         converter_power_on, // analog power enable
  output logic      [adcc_pkg::MUX_W-1:0] input_mux_sel, // one-hot analog mux
  output logic                         ref_from_supply // 1: analog_supply, 0: ref pin
);
  import adcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]       ctrl_ff;
  logic [7:0]       cfg_ff;
  logic             busy_ff;
  logic [RES_W-1:0] result_ff;
  logic [IRQ_W-1:0] irq_status_ff;
  logic [IRQ_W-1:0] irq_enable_ff;
  logic             start_seen_ff;
  logic             done_sync1_ff;
  logic             done_sync2_ff;
  logic             done_sync3_ff;
  logic             done_level_ff;
  logic [4:0]       clk_cnt_ff;
  adcc_state_e      state_ff;
  adcc_state_e      nxt_state;

  logic             wr_en;
  logic             wr_ctrl;
  logic             wr_cfg;
  logic             wr_irq_en;
  logic             wr_irq_clr;
  logic             done_rise;
  logic             start_fire;
  logic             done_evt;
  logic             div_tick;
  logic             power;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == ADDR_CONV_CTRL) || (a == ADDR_SRC_CFG) ||
                 (a == ADDR_RES_HIGH) || (a == ADDR_RES_LOW) ||
                 (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_ENABLE) ||
                 (a == ADDR_IRQ_CLEAR) || (a == ADDR_CONV_RESULT);
  endfunction : addr_known

  // write strobe for one register; wr_en already holds the access qualifier
  function automatic logic wr_hit(input logic acc, input logic [7:0] a,
                                  input logic [7:0] target);
    wr_hit = acc && (a == target);
  endfunction : wr_hit

  // writes commit only at the access edge where pready is sampled high
  assign wr_en      = psel && penable && pwrite && pready;
  assign wr_ctrl    = wr_hit(wr_en, paddr, ADDR_CONV_CTRL);
  assign wr_cfg     = wr_hit(wr_en, paddr, ADDR_SRC_CFG);
  assign wr_irq_en  = wr_hit(wr_en, paddr, ADDR_IRQ_ENABLE);
  assign wr_irq_clr = wr_hit(wr_en, paddr, ADDR_IRQ_CLEAR);
  assign power      = ctrl_ff[BIT_POWER];

  ////////////////////////////////////////////////////////////////////////////
  // apb: zero wait states
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !addr_known(paddr);
    end
  end

  // read data registered during setup so it stands in the access phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ADDR_CONV_CTRL:  prdata <= {24'h00_0000, ctrl_ff[7], busy_ff, ctrl_ff[5:0]};
        ADDR_SRC_CFG:    prdata <= {24'h00_0000, cfg_ff};
        ADDR_RES_HIGH:   prdata <= ctrl_ff[BIT_JUSTIFY] ?             // [RULE16]
                                   {24'h00_0000, 4'h0, result_ff[11:8]} :
                                   {24'h00_0000, result_ff[11:4]};
        ADDR_RES_LOW:    prdata <= ctrl_ff[BIT_JUSTIFY] ?             // [RULE16]
                                   {24'h00_0000, result_ff[7:0]} :
                                   {24'h00_0000, result_ff[3:0], 4'h0};
        ADDR_IRQ_STATUS: prdata <= {30'h0000_0000, irq_status_ff};
        ADDR_IRQ_ENABLE: prdata <= {30'h0000_0000, irq_enable_ff};
        ADDR_CONV_RESULT: prdata <= {20'h0_0000, result_ff};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= CTRL_RESET;                                          // [RULE18]
    end else if (wr_ctrl) begin
      ctrl_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= CFG_RESET;                                            // [RULE18]
    end else if (wr_cfg) begin
      cfg_ff <= pwdata[7:0];
    end
  end

  // start armed on rising write, fired on the falling write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_seen_ff <= 1'b0;
    end else if (wr_ctrl) begin
      if (!ctrl_ff[BIT_START] && pwdata[BIT_START]) begin
        start_seen_ff <= 1'b1;                                        // [RULE14]
      end else if (!pwdata[BIT_START]) begin
        start_seen_ff <= 1'b0;
      end
    end
  end

  assign start_fire = wr_ctrl &&
                      start_seen_ff && ctrl_ff[BIT_START] && !pwdata[BIT_START] &&
                      power && state_ff == ADCC_IDLE;                 // [RULE14]

  ////////////////////////////////////////////////////////////////////////////
  // completion input from analog core, three-stage sampler
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_sync1_ff <= 1'b0;
      done_sync2_ff <= 1'b0;
      done_sync3_ff <= 1'b0;
    end else begin
      done_sync1_ff <= conv_done;
      done_sync2_ff <= done_sync1_ff;
      done_sync3_ff <= done_sync2_ff;
    end
  end

  // a level counts once the last two stages agree, so one odd sample is no edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_level_ff <= 1'b0;
    end else if (done_sync2_ff == done_sync3_ff) begin
      done_level_ff <= done_sync3_ff;
    end
  end

  assign done_rise = done_sync2_ff && done_sync3_ff && !done_level_ff;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  adcc_clkdiv #(
    .DIV_W (7)
  ) u_clkdiv (
    .clk     (clk),
    .rst     (rst),
    .run     (power),                                                 // [RULE17]
    .div_sel (cfg_ff[DIV_HI:0]),                                      // [RULE12] [RULE13]
    .tick    (div_tick)
  );

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ADCC_IDLE:    if (start_fire) nxt_state = ADCC_SAMPLE;
      ADCC_SAMPLE:  if (div_tick && clk_cnt_ff == 5'(CONV_CLKS - 1)) nxt_state = ADCC_CONVERT;
      ADCC_CONVERT: if (done_rise) nxt_state = ADCC_IDLE;
    endcase
    // power off aborts; result left untouched
    if (!power) nxt_state = ADCC_IDLE;                                // [RULE17]
  end

  assign done_evt = state_ff == ADCC_CONVERT && nxt_state == ADCC_IDLE && power;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ADCC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_cnt_ff <= 5'h00;
    end else if (state_ff != ADCC_SAMPLE) begin
      clk_cnt_ff <= 5'h00;
    end else if (div_tick) begin
      clk_cnt_ff <= clk_cnt_ff + 5'h01;
    end
  end

  // busy is not writable by software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else if (start_fire) begin
      busy_ff <= 1'b1;                                                // [RULE15] [RULE18]
    end else if (done_evt || !power) begin
      busy_ff <= 1'b0;                                                // [RULE15]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_ff <= '0;
    end else if (done_evt) begin
      result_ff <= conv_data;                                         // [RULE17]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= state_ff == ADCC_SAMPLE && nxt_state == ADCC_CONVERT;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_clk_tick <= 1'b0;
    end else begin
      conv_clk_tick <= div_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog routing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      converter_power_on <= 1'b0;
    end else begin
      converter_power_on <= power;                                    // [RULE17]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_from_supply <= 1'b0;                                        // [RULE8]
    end else begin
      // only code 01 selects the supply; 00 and 1x use the pin
      ref_from_supply <= cfg_ff[REF_HI:REF_LO] == REF_ANALOG;         // [RULE9] [RULE10]
    end
  end

  // software must keep channel off-range with an internal source; here an internal source never sets a pin select bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      input_mux_sel <= '0;
    end else begin
      input_mux_sel <= '0;
      unique case (cfg_ff[SRC_HI:SRC_LO])
        SRC_BANDGAP: input_mux_sel[MUX_BANDGAP] <= 1'b1;              // [RULE3]
        SRC_SMOKE_A: input_mux_sel[MUX_SMOKE_A] <= 1'b1;              // [RULE4]
        SRC_SMOKE_B: input_mux_sel[MUX_SMOKE_B] <= 1'b1;              // [RULE5]
        SRC_HORN:    input_mux_sel[MUX_HORN] <= 1'b1;                 // [RULE6]
        default: begin
          // 000 and 101-111 route the external pin
          if (ctrl_ff[CHSEL_HI:0] <= CHAN_LAST) begin                 // [RULE1] [RULE2] [RULE19]
            input_mux_sel[ctrl_ff[2:0]] <= 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts
  assign irq_set = {start_fire, done_evt};
  assign irq_clr = wr_irq_clr ?
                   pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status_ff <= '0;
    end else begin
      // set wins over a clear in the same cycle
      irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;          // [RULE15]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_enable_ff <= '0;
    end else if (wr_irq_en) begin
      irq_enable_ff <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_ff & irq_enable_ff);
    end
  end
endmodule : adcc_top

//--- tb/adcc_top_props.sv
`timescale 1ns/1ps
module adcc_top_props
  import adcc_pkg::*;
(
  input wire logic                       clk,                // clock
  input wire logic                       rst,                // reset
  input wire logic                       psel,               // apb select
  input wire logic                       penable,            // apb enable
  input wire logic                       pwrite,             // apb write
  input wire logic [7:0]                 paddr,              // apb address
  input wire logic [31:0]                pwdata,             // apb data
  input wire logic                       pready,             // apb ready
  input wire logic                       pslverr,            // apb error
  input wire logic                       irq,                // interrupt
  input wire logic                       conv_done,          // core done
  input wire logic                       conv_start,         // core start
  input wire logic                       converter_power_on, // power
  input wire logic [adcc_pkg::MUX_W-1:0] input_mux_sel,      // mux select
  input wire logic                       ref_from_supply     // reference
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] ctrl_sh;
  logic [7:0] cfg_sh;
  logic [7:0] en_sh;
  logic [1:0] quiet;
  logic       pend;
  logic       done_q;
  logic [2:0] src;
  logic [3:0] chan;
  wire        wr = psel && penable && pready && pwrite;
  assign src  = cfg_sh[SRC_HI:SRC_LO];
  assign chan = ctrl_sh[CHSEL_HI:0];
  ////////////////////////////////////////////////////////////////////////////////
  // shadow settings; quiet saturates so outputs are judged only once settled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_sh <= 8'h00;
      cfg_sh  <= 8'h00;
      en_sh   <= 8'h00;
      quiet   <= 2'h0;
    end else begin
      if (wr && paddr == ADDR_CONV_CTRL) ctrl_sh <= pwdata[7:0];
      if (wr && paddr == ADDR_SRC_CFG) cfg_sh <= pwdata[7:0];
      if (wr && paddr == ADDR_IRQ_ENABLE) en_sh <= pwdata[7:0];
      quiet <= wr ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend   <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= conv_done;
      if (conv_start) pend <= 1'b1;
      else if ((conv_done && !done_q) || !converter_power_on) pend <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_mux_external: assert property (quiet == 2'h3 && !(src inside {[3'h1:3'h4]}) |->
    input_mux_sel == (chan <= CHAN_LAST ? MUX_W'(1) << chan : '0))
    else $error("mux wrong for external source");
  a_mux_internal: assert property (quiet == 2'h3 && src inside {[3'h1:3'h4]} |->
    input_mux_sel == MUX_W'(1) << (MUX_BANDGAP + src - 1))
    else $error("mux wrong for internal source");
  a_ref_select: assert property (quiet == 2'h3 |->
    ref_from_supply == (cfg_sh[REF_HI:REF_LO] == REF_ANALOG))
    else $error("reference select wrong");
  a_power_follow: assert property (quiet == 2'h3 |-> converter_power_on == ctrl_sh[BIT_POWER])
    else $error("power enable does not follow register");
  a_start_single: assert property (conv_start |=> !conv_start [*8])
    else $error("start pulse too long");
  a_start_powered: assert property (conv_start |-> converter_power_on)
    else $error("start while powered off");
  a_done_irq: assert property (conv_done && !done_q && pend && en_sh[IRQ_DONE] |-> ##[1:6] irq)
    else $error("no interrupt after completion");
  a_irq_masked: assert property (quiet == 2'h3 && en_sh == 8'h00 |-> !irq)
    else $error("interrupt while all masked");
  a_reset_quiet: assert property ($past(rst) |-> !irq && !conv_start && !converter_power_on)
    else $error("outputs not cleared by reset");
  c_start: cover property (conv_start);
  c_done: cover property (conv_done && !done_q && pend);
  c_slverr: cover property (pready && pslverr);
endmodule : adcc_top_props

bind adcc_top adcc_top_props u_props (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .irq, .conv_done, .conv_start, .converter_power_on, .input_mux_sel,
  .ref_from_supply);

//--- tb/adc_control_registers_bench.sv
`timescale 1ns/1ps
module adc_control_registers_bench;
  import adcc_pkg::*;
  logic             clk, rst, psel, penable, pwrite, conv_done, err, j;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic             pready, pslverr, irq, conv_clk_tick, conv_start, converter_power_on;
  logic             ref_from_supply;
  logic [RES_W-1:0] conv_data, res;
  logic [MUX_W-1:0] input_mux_sel;
  logic [2:0]       src;
  logic [3:0]       chan;
  int               failures, check_count, seed, last, nt, n;
  adcc_top uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .conv_done, .conv_data, .conv_clk_tick, .conv_start, .converter_power_on,
    .input_mux_sel, .ref_from_supply);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) failures++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  function automatic logic [31:0] exp_mux(input logic [2:0] s, input logic [3:0] c);
    if (s inside {[3'h1:3'h4]}) return 32'h1 << (MUX_BANDGAP + s - 1);
    return (c <= CHAN_LAST) ? 32'h1 << c : 32'h0;
  endfunction : exp_mux
  function automatic logic [31:0] res_hi(input logic jf, input logic [11:0] r);
    return jf ? {28'h0, r[11:8]} : {24'h0, r[11:4]};
  endfunction : res_hi
  function automatic logic [31:0] res_lo(input logic jf, input logic [11:0] r);
    return jf ? {24'h0, r[7:0]} : {24'h0, r[3:0], 4'h0};
  endfunction : res_lo
  task automatic give_verdict;
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(30000 * 50);
    failures++;
    give_verdict();
  end
  initial begin
    seed = 32'h644a;
    {rst, psel, penable, pwrite, conv_done} = 5'h10;
    {paddr, pwdata, conv_data, res} = '0;
    failures = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdchk(ADDR_CONV_CTRL, {24'h0, CTRL_RESET});
    rdchk(ADDR_SRC_CFG, {24'h0, CFG_RESET});
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(ADDR_CONV_CTRL, 32'h5F);
    rdchk(ADDR_CONV_CTRL, 32'h1F);
    for (int i = 0; i < 16; i++) begin
      src = i[2:0];
      chan = 4'($random(seed));
      if (src inside {[3'h1:3'h4]}) chan[3] = 1'b1;
      if (i == 8) chan = CHAN_LAST;
      if (i == 13) chan = 4'h8;
      wr(ADDR_CONV_CTRL, {28'h0, chan});
      wr(ADDR_SRC_CFG, {24'h0, src, i[3:2], 3'($random(seed))});
      repeat (3) @(posedge clk);
      chk({20'h0, input_mux_sel}, exp_mux(src, chan));
      chk({31'h0, ref_from_supply}, {31'h0, i[3:2] == 2'h1});
    end
    wr(ADDR_IRQ_ENABLE, 32'h1);
    for (int dv = 0; dv < 8; dv++) begin
      j = dv[0];
      wr(ADDR_SRC_CFG, {29'h0, dv[2:0]});
      wr(ADDR_CONV_CTRL, {24'h0, 3'h5, j, 4'h0});
      wr(ADDR_CONV_CTRL, {24'h0, 3'h1, j, 4'h0});
      rdchk(ADDR_CONV_CTRL, {24'h0, 3'h3, j, 4'h0});
      last = -1;
      nt = 0;
      n = 0;
      while (conv_start !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n++;
        if (conv_clk_tick === 1'b1) begin
          if (last >= 0) chk(n - last, 32'h1 << dv);
          last = n;
          nt++;
        end
      end
      chk({31'h0, conv_start}, 32'h1);
      chk({31'h0, nt > 2}, 32'h1);
      res = 12'($random(seed));
      conv_data <= res;
      conv_done <= 1'b1;
      repeat (6) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rdchk(ADDR_CONV_CTRL, {24'h0, 3'h1, j, 4'h0});
      rdchk(ADDR_RES_HIGH, res_hi(j, res));
      rdchk(ADDR_RES_LOW, res_lo(j, res));
      rdchk(ADDR_IRQ_STATUS, 32'h3);
      conv_done <= 1'b0;
      wr(ADDR_IRQ_CLEAR, 32'h3);
      rdchk(ADDR_IRQ_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    // power drop in mid-sampling: result must survive a late done
    wr(ADDR_CONV_CTRL, 32'hA0);
    wr(ADDR_CONV_CTRL, 32'h20);
    wr(ADDR_CONV_CTRL, 32'h00);
    repeat (40) @(posedge clk);
    conv_data <= ~res;
    conv_done <= 1'b1;
    repeat (5) @(posedge clk);
    rdchk(ADDR_CONV_RESULT, {20'h0, res});
    chk({31'h0, irq}, 32'h0);
    give_verdict();
  end
endmodule : adc_control_registers_bench
